// *** hltm_defs.svh ***
`ifndef HLTM_DEFS_SVH
`define HLTM_DEFS_SVH
// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define HLTM_OFF_CTRL    4'h0
`define HLTM_OFF_PERIOD  4'h4
`define HLTM_OFF_COUNT   4'h8
`define HLTM_CTRL_RUN    0
`define HLTM_CTRL_MODE_L 8
`define HLTM_CTRL_MODE_H 12
`define HLTM_CNT_START   8
`define HLTM_RST_PERIOD  8'hFF
// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define HLTM_M_SWGATE    5'h00
`define HLTM_M_GATE_HI   5'h01
`define HLTM_M_GATE_LO   5'h02
`define HLTM_M_RST_ANY   5'h03
`define HLTM_M_RST_RISE  5'h04
`define HLTM_M_RST_FALL  5'h05
`define HLTM_M_RST_LOW   5'h06
`define HLTM_M_RST_HIGH  5'h07
`define HLTM_M_OS_SW     5'h08
`define HLTM_M_OS_RISE   5'h09
`define HLTM_M_OS_FALL   5'h0A
`define HLTM_M_OS_ANY    5'h0B
`define HLTM_M_OSL_RISE  5'h0C
`define HLTM_M_OSL_FALL  5'h0D
`define HLTM_M_OSV_LOW   5'h0E
`define HLTM_M_OSV_HIGH  5'h0F
`define HLTM_M_MS_RISE   5'h11
`define HLTM_M_MS_FALL   5'h12
`define HLTM_M_MS_ANY    5'h13
`define HLTM_M_LV_HIGH   5'h16
`define HLTM_M_LV_LOW    5'h17
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HLTM_RESTART_TICKS 2'h2
`endif

// *** hltm_pkg.sv ***
package hltm_pkg;
	typedef struct packed {
		logic [4:0] mode;
		logic       run;
	} hltm_ctrl_s;

	typedef struct packed {
		logic       rst_e;
		logic       lvl;
		logic       gate;
		logic       need_start;
		logic       start_ev;
		logic       one_shot;
		logic       mono;
		logic       nop;
	} hltm_ctl_s;
endpackage : hltm_pkg

// *** hltm_timer.sv ***
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
`include "hltm_defs.svh"
module hltm_timer #(
	parameter int W = 8
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         tick_i,
	input  wire logic         ext_reset_signal_i,
	input  wire logic         debug_i,
	input  wire logic [3:0]   address_i,
	input  wire logic         read_i,
	input  wire logic         write_i,
	input  wire logic [31:0]  writedata_i,
	output logic      [31:0]  readdata_o,
	output logic              waitrequest_o,
	output logic      [W-1:0] count_value_o
);
	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	hltm_pkg::hltm_ctrl_s ctrl_q, ctrl_d;
	logic [W-1:0] period_q, period_d, cnt_q, cnt_d;
	logic [31:0]  rdata_d;
	logic         wait_d, clr_run, started_q, started_d;
	logic         wr_ok;

	assign wr_ok = write_i & ~waitrequest_o;

	always_comb begin
		wait_d  = 1'b1;
		rdata_d = readdata_o;
		if ((read_i | write_i) & waitrequest_o) begin
			wait_d  = 1'b0;
			rdata_d = 32'h0000_0000;
			unique case (address_i)
				`HLTM_OFF_CTRL: begin
					rdata_d[`HLTM_CTRL_RUN] = ctrl_q.run;
					rdata_d[`HLTM_CTRL_MODE_H:`HLTM_CTRL_MODE_L] = ctrl_q.mode;
				end
				`HLTM_OFF_PERIOD: rdata_d[W-1:0] = period_q;
				`HLTM_OFF_COUNT: begin
					rdata_d[W-1:0] = cnt_q;
					rdata_d[`HLTM_CNT_START] = started_q;
				end
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		ctrl_d   = ctrl_q;
		period_d = period_q;
		if (clr_run) begin
			ctrl_d.run = 1'b0;
		end
		// Software write after hardware clear so a restart is not lost
		if (wr_ok && address_i == `HLTM_OFF_CTRL) begin
			ctrl_d.run  = writedata_i[`HLTM_CTRL_RUN];
			ctrl_d.mode = writedata_i[`HLTM_CTRL_MODE_H:`HLTM_CTRL_MODE_L];
		end
		if (wr_ok && address_i == `HLTM_OFF_PERIOD) begin
			period_d = writedata_i[W-1:0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q        <= '0;
			period_q      <= W'(`HLTM_RST_PERIOD);
			readdata_o    <= 32'h0000_0000;
			waitrequest_o <= 1'b1;
		end else begin
			ctrl_q        <= ctrl_d;
			period_q      <= period_d;
			readdata_o    <= rdata_d;
			waitrequest_o <= wait_d;
		end
	end

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	// Pin stage: three flops, level accepted once stages two and three agree
	logic e1_q, e2_q, e3_q, elvl_q, elvl_d;
	// Timer-clock stages, giving at least two timer clocks of delay
	logic ea_q, eb_q, ec_q, ea_d, eb_d, ec_d;
	logic rs1_q, rs2_q, rs1_d, rs2_d;

	always_comb begin
		elvl_d = (e2_q == e3_q) ? e3_q : elvl_q;
		ea_d   = ea_q;
		eb_d   = eb_q;
		ec_d   = ec_q;
		rs1_d  = rs1_q;
		rs2_d  = rs2_q;
		if (tick_i) begin
			ea_d  = elvl_q;
			eb_d  = ea_q;
			ec_d  = eb_q;
			rs1_d = ctrl_q.run;
			rs2_d = rs1_q;
		end
		// A cleared run must not linger in the pipeline and rearm the shot
		if (clr_run) begin
			rs1_d = 1'b0;
			rs2_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{e1_q, e2_q, e3_q, elvl_q} <= 4'h0;
			{ea_q, eb_q, ec_q}         <= 3'h0;
			{rs1_q, rs2_q}             <= 2'h0;
		end else begin
			e1_q   <= ext_reset_signal_i;
			e2_q   <= e1_q;
			e3_q   <= e2_q;
			elvl_q <= elvl_d;
			ea_q   <= ea_d;
			eb_q   <= eb_d;
			ec_q   <= ec_d;
			rs1_q  <= rs1_d;
			rs2_q  <= rs2_d;
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	function automatic logic edge_sel(input logic [1:0] sel, input logic r, input logic f);
		edge_sel = (sel[0] & r) | (sel[1] & f);
	endfunction : edge_sel

	logic rise, fall, active, match;
	hltm_pkg::hltm_ctl_s c;
	logic [1:0] hold_q, hold_d;

	assign rise  = eb_q & ~ec_q;
	assign fall  = ~eb_q & ec_q;
	assign match = (cnt_q == period_q);

	always_comb begin
		c      = '0;
		c.gate = 1'b1;
		unique case (ctrl_q.mode)
			`HLTM_M_SWGATE:   c.gate = 1'b1;
			`HLTM_M_GATE_HI:  c.gate = eb_q;
			`HLTM_M_GATE_LO:  c.gate = ~eb_q;
			`HLTM_M_RST_ANY,
			`HLTM_M_RST_RISE,
			`HLTM_M_RST_FALL: begin
				// Any, rise, fall map to selects 11, 01, 10; an increment wraps any-edge to 00
				c.rst_e = edge_sel({ctrl_q.mode[0], ~^ctrl_q.mode[1:0]}, rise, fall);
			end
			`HLTM_M_RST_LOW:  c.lvl = ~eb_q;
			`HLTM_M_RST_HIGH: c.lvl = eb_q;
			`HLTM_M_OS_SW:    c.one_shot = 1'b1;
			`HLTM_M_OS_RISE,
			`HLTM_M_OS_FALL,
			`HLTM_M_OS_ANY: begin
				c.one_shot   = 1'b1;
				c.need_start = 1'b1;
				c.start_ev   = edge_sel(ctrl_q.mode[1:0], rise, fall);
			end
			`HLTM_M_OSL_RISE,
			`HLTM_M_OSL_FALL: begin
				c.one_shot   = 1'b1;
				c.need_start = 1'b1;
				c.start_ev   = ctrl_q.mode[0] ? fall : rise;
				c.rst_e      = c.start_ev & started_q;
			end
			`HLTM_M_OSV_LOW,
			`HLTM_M_OSV_HIGH: begin
				c.one_shot   = 1'b1;
				c.need_start = 1'b1;
				c.start_ev   = ctrl_q.mode[0] ? fall : rise;
				c.lvl        = ctrl_q.mode[0] ? eb_q : ~eb_q;
			end
			`HLTM_M_MS_RISE,
			`HLTM_M_MS_FALL,
			`HLTM_M_MS_ANY: begin
				c.mono       = 1'b1;
				c.need_start = 1'b1;
				c.start_ev   = edge_sel(ctrl_q.mode[1:0], rise, fall);
			end
			`HLTM_M_LV_HIGH,
			`HLTM_M_LV_LOW: begin
				c.one_shot = 1'b1;
				c.gate     = ctrl_q.mode[0] ? ~eb_q : eb_q;
				c.lvl      = ~c.gate;
			end
			default: c.nop = 1'b1;
		endcase
		if (debug_i) begin
			c.gate     = 1'b1;
			c.lvl      = 1'b0;
			c.rst_e    = 1'b0;
			c.start_ev = 1'b0;
		end
	end

	assign active = rs2_q & c.gate & ~c.nop & (~c.need_start | started_q);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_comb begin
		cnt_d     = cnt_q;
		hold_d    = hold_q;
		started_d = started_q;
		clr_run   = 1'b0;
		if (tick_i) begin
			if (!rs2_q) begin
				started_d = 1'b0;
			end else if (c.need_start & c.start_ev) begin
				started_d = 1'b1;
			end
			// External clears never write the run bit
			if (rs2_q & (c.lvl | c.rst_e)) begin
				cnt_d  = '0;
				hold_d = `HLTM_RESTART_TICKS;
			end else if (hold_q != 2'h0) begin
				hold_d = hold_q - 2'h1;
			end else if (active) begin
				if (match) begin
					cnt_d = '0;
					if (c.one_shot | c.mono) begin
						started_d = 1'b0;
					end
					clr_run = c.one_shot;
				end else begin
					cnt_d = cnt_q + W'(1);
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q         <= '0;
			hold_q        <= 2'h0;
			started_q     <= 1'b0;
			count_value_o <= '0;
		end else begin
			cnt_q         <= cnt_d;
			hold_q        <= hold_d;
			started_q     <= started_d;
			count_value_o <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_swgate_hold;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(tick_i && ctrl_q.mode == `HLTM_M_SWGATE && !rs2_q) |=> $stable(cnt_q);
	endproperty
	a_swgate_hold: assert property (p_swgate_hold) else $error("count moved while stopped");

	property p_wrap;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(tick_i && hold_q == 2'h0 && active && match && !c.lvl && !c.rst_e)
			|=> (cnt_q == '0);
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap to zero on match");

	property p_gate_hi;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(tick_i && ctrl_q.mode == `HLTM_M_GATE_HI && !eb_q && !debug_i) |=> $stable(cnt_q);
	endproperty
	a_gate_hi: assert property (p_gate_hi) else $error("gate high mode counted on low");

	property p_gate_lo;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(tick_i && ctrl_q.mode == `HLTM_M_GATE_LO && eb_q && !debug_i) |=> $stable(cnt_q);
	endproperty
	a_gate_lo: assert property (p_gate_lo) else $error("gate low mode counted on high");

	property p_edge_rst;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(tick_i && ctrl_q.mode == `HLTM_M_RST_RISE && rs2_q && rise && !debug_i)
			|=> (cnt_q == '0 && hold_q == `HLTM_RESTART_TICKS);
	endproperty
	a_edge_rst: assert property (p_edge_rst) else $error("rising edge did not clear");

	property p_restart;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(tick_i && hold_q != 2'h0) |=> (cnt_q == '0);
	endproperty
	a_restart: assert property (p_restart) else $error("counted during restart delay");

	property p_oneshot_end;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(tick_i && ctrl_q.mode == `HLTM_M_OS_SW && hold_q == 2'h0 && active && match && !wr_ok)
			|=> (!ctrl_q.run && cnt_q == '0 && !rs2_q);
	endproperty
	a_oneshot_end: assert property (p_oneshot_end) else $error("one-shot did not stop");

	property p_mono_end;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(tick_i && c.mono && ctrl_q.run && hold_q == 2'h0 && active && match && !wr_ok)
			|=> (ctrl_q.run && cnt_q == '0 && !started_q);
	endproperty
	a_mono_end: assert property (p_mono_end) else $error("monostable end wrong");

	property p_reserved;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(tick_i && c.nop && hold_q == 2'h0) |=> $stable(cnt_q);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved mode counted");

	c_wrap:    cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) tick_i && active && match);
	c_hw_rst:  cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) tick_i && rs2_q && c.rst_e);
	c_os_done: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) clr_run);
	c_bus_rd:  cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) read_i && !waitrequest_o);
endmodule : hltm_timer

// *** hltm_ext_src.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// External trigger source
// ----------------------------------------------------------------
module hltm_ext_src (
	input  wire logic sys_clk_i,
	input  wire logic rst_b_i,
	input  wire logic tick_i,
	input  wire logic level_i,
	output logic      ext_o
);
	logic [3:0] held_q;
	logic [3:0] held_d;
	logic       ext_d;
	// Requests closer than the spacing wait; a level change undone before then is dropped
	always_comb begin
		ext_d  = ext_o;
		held_d = (tick_i && held_q != 4'hF) ? held_q + 4'h1 : held_q;
		if (level_i != ext_o && held_q >= 4'h6) begin
			ext_d  = level_i;
			held_d = 4'h0;
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ext_o  <= 1'h0;
			held_q <= 4'h0;
		end else begin
			ext_o  <= ext_d;
			held_q <= held_d;
		end
	end
endmodule : hltm_ext_src

// *** tb_top.sv ***
`timescale 1ns/100ps
`include "hltm_defs.svh"
module tb_top;
	localparam logic [3:0] ctl_a = `HLTM_OFF_CTRL;
	localparam logic [3:0] per_a = `HLTM_OFF_PERIOD;
	localparam logic [3:0] cnt_a = `HLTM_OFF_COUNT;
	logic        sys_clk_i   = 1'h0;
	logic        rst_b_i     = 1'h0;
	logic        tick_i      = 1'h0;
	logic        level       = 1'h0;
	logic        debug_i     = 1'h0;
	logic [3:0]  address_i   = 4'h0;
	logic        read_i      = 1'h0;
	logic        write_i     = 1'h0;
	logic [31:0] writedata_i = 32'h0;
	logic        ext;
	logic [31:0] readdata_o;
	logic        waitrequest_o;
	logic [7:0]  count_value_o;
	logic [31:0] rd;
	logic [31:0] snap;
	wire  [31:0] cnt_w = {24'h0, count_value_o};
	int          fails    = 0;
	int          compares = 0;
	int          n;
	logic        fin;

	always #2.5 sys_clk_i = ~sys_clk_i;
	// Timer clock at half rate so holds between ticks are visible
	always @(posedge sys_clk_i) tick_i <= ~tick_i;

	hltm_timer #(.W(8)) dut (
		.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .tick_i(tick_i),
		.ext_reset_signal_i(ext), .debug_i(debug_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
		.readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.count_value_o(count_value_o));
	hltm_ext_src src (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .tick_i(tick_i),
		.level_i(level), .ext_o(ext));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task close_out;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk_i);
		address_i   <= a;
		writedata_i <= d;
		write_i     <= wr;
		read_i      <= !wr;
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk_i);
			if (waitrequest_o === 1'h0) break;
		end
		rd = readdata_o;
		write_i <= 1'h0;
		read_i  <= 1'h0;
		if (i == 50) begin
			fails++;
			close_out();
		end
	endtask : bus

	task ticks(input int t);
		repeat (2 * t) @(posedge sys_clk_i);
	endtask : ticks

	// Waits for a change of count, or for a given count
	task wt(input logic chg, input logic [7:0] v, input int lim);
		int         i;
		logic [7:0] s;
		s = count_value_o;
		for (i = 0; i < lim; i++) begin
			@(posedge sys_clk_i);
			if (chg ? (count_value_o !== s) : (count_value_o === v)) break;
		end
		if (i == lim) begin
			fails++;
			close_out();
		end
	endtask : wt

	task setup(input logic [4:0] m, input logic [7:0] p, input logic r);
		bus(1'h1, per_a, {24'h0, p});
		bus(1'h1, ctl_a, {19'h0, m, 7'h0, r});
	endtask : setup

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge sys_clk_i);
		rst_b_i <= 1'h1;
		bus(1'h0, ctl_a, 32'h0);
		chk("ctrl", rd, 32'h0);
		bus(1'h0, per_a, 32'h0);
		chk("period", rd, {24'h0, `HLTM_RST_PERIOD});
		bus(1'h1, cnt_a, 32'h55);
		bus(1'h0, cnt_a, 32'h0);
		chk("count", rd, 32'h0);
		bus(1'h0, 4'hC, 32'h0);
		chk("unmapped", rd, 32'h0);
		$display("test reset done");
		setup(5'h00, 8'h03, 1'h1);
		wt(1'h0, 8'h03, 200);
		wt(1'h1, 8'h00, 50);
		chk("wrap", cnt_w, 32'h0);
		bus(1'h1, ctl_a, 32'h0);
		// Run bit needs two ticks to reach the counter
		ticks(4);
		snap = cnt_w;
		ticks(10);
		chk("run hold", cnt_w, snap);
		$display("test swgate done");
		setup(5'h01, 8'h03, 1'h1);
		ticks(12);
		snap = cnt_w;
		ticks(10);
		chk("gate hi", cnt_w, snap);
		level <= 1'h1;
		wt(1'h1, 8'h00, 200);
		setup(5'h02, 8'h03, 1'h1);
		ticks(12);
		snap = cnt_w;
		ticks(10);
		chk("gate lo", cnt_w, snap);
		$display("test gate done");
		for (int k = 3; k < 6; k++) begin
			fin = (k == 4);
			setup(5'(k), 8'hFF, 1'h1);
			level <= !fin;
			ticks(20);
			level <= fin;
			wt(1'h0, 8'h00, 60);
			n = 0;
			while (count_value_o === 8'h00 && n < 100) begin
				@(posedge sys_clk_i);
				n++;
			end
			chk("restart", cnt_w, 32'h1);
			chk("zero hold", 32'(n >= 4), 32'h1);
			bus(1'h0, ctl_a, 32'h0);
			chk("run kept", rd & 32'h1, 32'h1);
			bus(1'h1, ctl_a, 32'h0);
		end
		$display("test limit done");
		setup(5'h08, 8'h10, 1'h1);
		wt(1'h0, 8'h10, 200);
		wt(1'h1, 8'h00, 50);
		chk("os end", cnt_w, 32'h0);
		bus(1'h0, ctl_a, 32'h0);
		chk("os run", rd & 32'h1, 32'h0);
		ticks(10);
		chk("os stop", cnt_w, 32'h0);
		setup(5'h09, 8'h30, 1'h1);
		ticks(12);
		chk("no edge", cnt_w, 32'h0);
		level <= 1'h1;
		wt(1'h1, 8'h00, 200);
		bus(1'h1, ctl_a, 32'h900);
		bus(1'h1, ctl_a, 32'h901);
		ticks(6);
		snap = cnt_w;
		ticks(10);
		chk("rearm", cnt_w, snap);
		level <= 1'h0;
		ticks(8);
		level <= 1'h1;
		wt(1'h0, 8'h30, 500);
		wt(1'h1, 8'h00, 50);
		chk("os edge end", cnt_w, 32'h0);
		$display("test oneshot done");
		setup(5'h12, 8'h06, 1'h1);
		ticks(12);
		level <= 1'h0;
		wt(1'h0, 8'h06, 300);
		wt(1'h1, 8'h00, 50);
		chk("ms end", cnt_w, 32'h0);
		bus(1'h0, ctl_a, 32'h0);
		chk("ms run", rd & 32'h1, 32'h1);
		ticks(8);
		chk("ms stop", cnt_w, 32'h0);
		setup(5'h10, 8'h06, 1'h1);
		level <= 1'h1;
		ticks(20);
		chk("reserved", cnt_w, 32'h0);
		debug_i <= 1'h1;
		setup(5'h04, 8'hFF, 1'h1);
		level <= 1'h0;
		ticks(20);
		snap = cnt_w;
		level <= 1'h1;
		ticks(14);
		chk("debug", 32'(cnt_w > snap), 32'h1);
		debug_i <= 1'h0;
		setup(5'h16, 8'hFF, 1'h1);
		ticks(12);
		level <= 1'h0;
		ticks(14);
		chk("level rst", cnt_w, 32'h0);
		level <= 1'h1;
		wt(1'h1, 8'h00, 200);
		$display("test misc done");
		bus(1'h1, ctl_a, 32'h0);
		ticks(4);
		setup(5'h0C, 8'hFF, 1'h1);
		snap = cnt_w;
		level <= 1'h0;
		ticks(10);
		chk("osl wait", cnt_w, snap);
		level <= 1'h1;
		wt(1'h1, 8'h00, 200);
		ticks(10);
		level <= 1'h0;
		ticks(8);
		level <= 1'h1;
		wt(1'h0, 8'h00, 60);
		bus(1'h0, cnt_a, 32'h0);
		chk("osl started", rd & 32'h100, 32'h100);
		bus(1'h1, ctl_a, 32'h0);
		ticks(4);
		setup(5'h0E, 8'hFF, 1'h1);
		level <= 1'h0;
		ticks(14);
		chk("osv hold", cnt_w, 32'h0);
		level <= 1'h1;
		wt(1'h1, 8'h00, 200);
		$display("test edge limit done");
		close_out();
	end
endmodule : tb_top
